// ===== src/isfa_top.sv
module isfa_top #(
   parameter logic COLOUR_UNIT = 1'b0,
   parameter logic [3:0] MOSAIC_DIGIT = 4'h1
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [7:0] sensor_pix,
   output isfa_pkg::isfa_pix_t stream_pix,
   output logic stream_valid,
   input wire logic stream_ready,
   output logic stream_active
);
   import isfa_pkg::*;
   typedef enum logic [2:0] {ST_IDLE, ST_GAP, ST_LINE, ST_SKIP, ST_WAIT} isfa_st_t;
   typedef struct packed {
      logic aw_got;
      logic w_got;
      logic [7:0] aw_addr;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      isfa_fmt_t fmt;
      logic chan_open;
      isfa_mode_t mode;
      logic rate_on;
      logic period_on;
      logic [15:0] burst_total;
      logic [31:0] period_cyc;
      logic [31:0] rate_mhz;
      logic [31:0] expose_cyc;
      logic recip_busy;
      logic recip_to_rate;
      logic [63:0] rem;
      logic [31:0] quo;
      logic [5:0] step;
      isfa_st_t st;
      logic stop_pend;
      logic [15:0] frames_left;
      logic [11:0] x;
      logic [11:0] y;
      logic [11:0] gap;
      logic [3:0] sub;
      logic [10:0] acc;
      logic [31:0] frame_cnt;
      logic [31:0] frames_done;
      isfa_pix_t out;
      logic out_valid;
   } isfa_state_t;
   isfa_state_t s_r, s_nxt;

   logic [7:0] pat_pix;
   logic [11:0] xs;
   logic [11:0] ys;
   logic wr_fire;
   logic [31:0] wmask;
   logic [31:0] wval;
   logic [31:0] frame_len;
   logic [31:0] rate_len;
   logic [11:0] lines_out;
   logic [31:0] min_len;
   logic [31:0] fmt_id;
   logic kill_now;

   // mirror by scanning coordinates backwards into the source
   assign xs = s_r.fmt.mirror_lr ? (WIDTH_MAX - 12'h001 - s_r.x) : s_r.x;
   assign ys = s_r.fmt.mirror_tb ? (HEIGHT_MAX - 12'h001 - s_r.y) : s_r.y;

   isfa_pattern u_pat (
      .aclk(aclk),
      .aresetn(aresetn),
      .pattern(s_r.fmt.pattern),
      .x(xs),
      .y(ys),
      .sensor(sensor_pix),
      .pix_out(pat_pix)
   );

   function automatic logic skip_ok(input logic [3:0] f);
      skip_ok = (f == 4'h1) || (f == 4'h2) || (f == 4'h4) || (f == 4'h8);
   endfunction : skip_ok

   // factors are one-hot, so the log is two ors
   function automatic logic [1:0] skip_log2(input logic [3:0] f);
      skip_log2 = {f[3] | f[2], f[3] | f[1]};
   endfunction : skip_log2

   assign wr_fire = s_r.aw_got && s_r.w_got && !s_r.bvalid;
   // kill must win over the engine's own state moves in the same cycle
   assign kill_now = wr_fire && (s_r.aw_addr == REG_CTRL) && s_r.w_strb[0] && s_r.w_data[CMD_KILL_BIT];
   always_comb begin
      wmask = {{8{s_r.w_strb[3]}}, {8{s_r.w_strb[2]}}, {8{s_r.w_strb[1]}}, {8{s_r.w_strb[0]}}};
   end

   assign fmt_id = s_r.fmt.coding ? (FMT_RAW8_BASE | {28'h0, MOSAIC_DIGIT}) : FMT_GRAY8;
   // shortest frame grows with output lines, which shrink with vertical skip
   assign lines_out = HEIGHT_MAX >> skip_log2(s_r.fmt.v_skip);
   assign min_len = 32'(HEIGHT_MAX) * 32'(LINE_GAP) + 32'(lines_out) * 32'(WIDTH_MAX);
   assign rate_len = (s_r.rate_on || s_r.period_on) ? s_r.period_cyc : min_len;
   assign frame_len = (s_r.expose_cyc > rate_len) ? s_r.expose_cyc :
                      ((rate_len < min_len) ? min_len : rate_len);

   always_comb begin
      s_nxt = s_r;
      wval = 32'h0;
      // AXI write channel: address and data taken in either order
      if (s_axi_awvalid && s_axi_awready) begin
         s_nxt.aw_got = 1'b1;
         s_nxt.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         s_nxt.w_got = 1'b1;
         s_nxt.w_data = s_axi_wdata;
         s_nxt.w_strb = s_axi_wstrb;
      end
      if (s_r.bvalid && s_axi_bready) s_nxt.bvalid = 1'b0;
      if (s_r.rvalid && s_axi_rready) s_nxt.rvalid = 1'b0;

      // reciprocal by restoring division, one quotient bit per cycle
      if (s_r.recip_busy) begin
         s_nxt.rem = {s_r.rem[62:0], 1'b0};
         if (s_nxt.rem[63:32] >= (s_r.recip_to_rate ? s_r.period_cyc : s_r.rate_mhz)) begin
            s_nxt.rem[63:32] = s_nxt.rem[63:32] - (s_r.recip_to_rate ? s_r.period_cyc : s_r.rate_mhz);
            s_nxt.quo = {s_r.quo[30:0], 1'b1};
         end else begin
            s_nxt.quo = {s_r.quo[30:0], 1'b0};
         end
         s_nxt.step = s_r.step + 6'h01;
         if (s_r.step == 6'h1F) begin
            s_nxt.recip_busy = 1'b0;
            if (s_r.recip_to_rate) s_nxt.rate_mhz = s_nxt.quo;
            else s_nxt.period_cyc = (s_nxt.quo > PERIOD_MAX_CYC) ? PERIOD_MAX_CYC : s_nxt.quo;
         end
      end

      if (wr_fire) begin
         s_nxt.aw_got = 1'b0;
         s_nxt.w_got = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = 2'b00;
         unique case (s_r.aw_addr)
            REG_CTRL: begin
               wval = s_r.w_data & wmask;
               if (s_r.w_strb[0]) s_nxt.chan_open = wval[CHAN_OPEN_BIT];
               // begin takes effect only with the channel open
               if (wval[CMD_BEGIN_BIT] && s_r.st == ST_IDLE && s_nxt.chan_open) begin
                  s_nxt.st = ST_GAP;
                  s_nxt.stop_pend = 1'b0;
                  s_nxt.frames_left = (s_r.mode == XFER_BURST) ? s_r.burst_total : 16'h0001;
                  s_nxt.x = 12'h000;
                  s_nxt.y = 12'h000;
                  s_nxt.gap = LINE_GAP;
                  s_nxt.frame_cnt = 32'h0;
               end
               if (wval[CMD_END_BIT] && s_r.st != ST_IDLE) s_nxt.stop_pend = 1'b1;
               if (wval[CMD_KILL_BIT]) begin
                  s_nxt.st = ST_IDLE;
                  s_nxt.out_valid = 1'b0;
               end
            end
            REG_FORMAT: begin
               wval = (s_r.w_data & wmask) | ({6'h00, s_r.fmt.slot, s_r.fmt.bit_size, 3'b0, s_r.fmt.coding,
                      s_r.fmt.pattern, 2'b0, s_r.fmt.mirror_tb, s_r.fmt.mirror_lr, s_r.fmt.v_skip,
                      s_r.fmt.h_skip} & ~wmask);
               s_nxt.fmt.mirror_lr = wval[MIRROR_LR_BIT];
               s_nxt.fmt.mirror_tb = wval[MIRROR_TB_BIT];
               if (wval[PATTERN_LSB +: 4] <= 4'(PAT_STRIPES)) s_nxt.fmt.pattern = isfa_pat_t'(wval[PATTERN_LSB +: 4]);
               s_nxt.fmt.coding = COLOUR_UNIT ? wval[CODING_BIT] : 1'b0;
               s_nxt.fmt.slot = wval[SLOT_LSB +: 2];
               if (!stream_active) begin
                  if (skip_ok(wval[HSKIP_LSB +: 4])) s_nxt.fmt.h_skip = wval[HSKIP_LSB +: 4];
                  if (skip_ok(wval[VSKIP_LSB +: 4])) s_nxt.fmt.v_skip = wval[VSKIP_LSB +: 4];
                  if (wval[BITSIZE_LSB +: 4] == BITSIZE_8) s_nxt.fmt.bit_size = BITSIZE_8;
               end
            end
            REG_ACQ: begin
               wval = s_r.w_data & wmask;
               if (s_r.w_strb[0] && wval[MODE_LSB +: 2] != 2'b11) s_nxt.mode = isfa_mode_t'(wval[MODE_LSB +: 2]);
               if (s_r.w_strb[0] && !stream_active) begin
                  s_nxt.rate_on = wval[RATE_ON_BIT];
                  s_nxt.period_on = wval[PERIOD_ON_BIT];
               end
            end
            REG_BURST: s_nxt.burst_total = (s_r.w_data[15:0] & wmask[15:0]) | (s_r.burst_total & ~wmask[15:0]);
            REG_PERIOD: if (!stream_active && !s_r.recip_busy && s_r.w_data != 32'h0) begin
               s_nxt.period_cyc = (s_r.w_data > PERIOD_MAX_CYC) ? PERIOD_MAX_CYC : s_r.w_data;
               s_nxt.recip_busy = 1'b1;
               s_nxt.recip_to_rate = 1'b1;
               s_nxt.rem = {32'h0, 32'(CLK_HZ / 1000)} * 64'd1000000;
               s_nxt.quo = 32'h0;
               s_nxt.step = 6'h00;
            end
            REG_RATE: if (!stream_active && !s_r.recip_busy && s_r.w_data != 32'h0) begin
               s_nxt.rate_mhz = s_r.w_data;
               s_nxt.recip_busy = 1'b1;
               s_nxt.recip_to_rate = 1'b0;
               s_nxt.rem = {32'h0, 32'(CLK_HZ / 1000)} * 64'd1000000;
               s_nxt.quo = 32'h0;
               s_nxt.step = 6'h00;
            end
            REG_EXPOSE: s_nxt.expose_cyc = (s_r.w_data & wmask) | (s_r.expose_cyc & ~wmask);
            default: s_nxt.bresp = 2'b10;
         endcase
      end

      if (s_axi_arvalid && s_axi_arready) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp = 2'b00;
         unique case (s_axi_araddr)
            REG_CTRL: s_nxt.rdata = {28'h0, s_r.chan_open, 3'b0};
            REG_FORMAT: s_nxt.rdata = {6'h0, s_r.fmt.slot, s_r.fmt.bit_size, 3'h0, s_r.fmt.coding,
                                       s_r.fmt.pattern, 2'h0, s_r.fmt.mirror_tb, s_r.fmt.mirror_lr,
                                       s_r.fmt.v_skip, s_r.fmt.h_skip};
            REG_PIXFMT: s_nxt.rdata = fmt_id;
            REG_ACQ: s_nxt.rdata = {26'h0, s_r.period_on, s_r.rate_on, 2'b0, s_r.mode};
            REG_BURST: s_nxt.rdata = {16'h0, s_r.burst_total};
            REG_PERIOD: s_nxt.rdata = s_r.period_cyc;
            REG_RATE: s_nxt.rdata = s_r.rate_mhz;
            REG_EXPOSE: s_nxt.rdata = s_r.expose_cyc;
            REG_STATUS: s_nxt.rdata = {s_r.frames_done[23:0], 5'h0, s_r.recip_busy, s_r.stop_pend, stream_active};
            REG_GEOM: s_nxt.rdata = frame_len;
            default: begin
               s_nxt.rdata = 32'h0;
               s_nxt.rresp = 2'b10;
            end
         endcase
      end

      // stream engine; output held while the sink stalls
      if (s_r.out_valid && stream_ready) s_nxt.out_valid = 1'b0;
      if (s_r.st != ST_IDLE && !kill_now && !(s_r.out_valid && !stream_ready)) begin
         s_nxt.frame_cnt = s_r.frame_cnt + 32'h1;
         unique case (s_r.st)
            ST_GAP: begin
               if (s_r.gap == 12'h000) begin
                  s_nxt.st = ST_LINE;
                  s_nxt.sub = 4'h0;
                  s_nxt.acc = 11'h0;
               end else s_nxt.gap = s_r.gap - 12'h001;
            end
            ST_LINE: begin
               // horizontal neighbours summed, scaled back to 8 bits
               s_nxt.acc = s_r.acc + {3'b0, pat_pix};
               s_nxt.sub = s_r.sub + 4'h1;
               s_nxt.x = s_r.x + 12'h001;
               if (s_r.sub + 4'h1 == s_r.fmt.h_skip) begin
                  s_nxt.sub = 4'h0;
                  s_nxt.acc = 11'h0;
                  s_nxt.out_valid = 1'b1;
                  s_nxt.out.data = 8'((s_r.acc + {3'b0, pat_pix}) >> skip_log2(s_r.fmt.h_skip));
                  s_nxt.out.sof = (s_r.x < {8'h0, s_r.fmt.h_skip}) && (s_r.y == 12'h000);
                  s_nxt.out.eol = (s_r.x == WIDTH_MAX - 12'h001);
               end
               if (s_r.x == WIDTH_MAX - 12'h001) begin
                  s_nxt.x = 12'h000;
                  s_nxt.y = s_r.y + 12'h001;
                  s_nxt.gap = LINE_GAP;
                  s_nxt.sub = 4'h0;
                  s_nxt.st = (s_r.fmt.v_skip == 4'h1) ? ST_GAP : ST_SKIP;
                  if (s_r.y + 12'h001 >= HEIGHT_MAX) s_nxt.st = ST_WAIT;
               end
            end
            ST_SKIP: begin
               // dropped lines only pass their short gap, no pixel time
               if (s_r.gap == 12'h000) begin
                  s_nxt.gap = LINE_GAP;
                  s_nxt.y = s_r.y + 12'h001;
                  s_nxt.sub = s_r.sub + 4'h1;
                  if (s_r.y + 12'h001 >= HEIGHT_MAX) s_nxt.st = ST_WAIT;
                  else if (s_r.sub + 4'h2 >= s_r.fmt.v_skip) s_nxt.st = ST_GAP;
               end else s_nxt.gap = s_r.gap - 12'h001;
            end
            ST_WAIT: begin
               if (s_r.frame_cnt + 32'h1 >= frame_len) begin
                  s_nxt.frames_done = s_r.frames_done + 32'h1;
                  s_nxt.frames_left = s_r.frames_left - 16'h0001;
                  s_nxt.frame_cnt = 32'h0;
                  s_nxt.x = 12'h000;
                  s_nxt.y = 12'h000;
                  s_nxt.gap = LINE_GAP;
                  s_nxt.st = ST_GAP;
                  // stop only on a frame boundary
                  if (s_r.stop_pend || (s_r.mode != XFER_CONT && s_r.frames_left <= 16'h0001)) begin
                     s_nxt.st = ST_IDLE;
                     s_nxt.stop_pend = 1'b0;
                  end
               end
            end
            default: s_nxt.st = ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_r <= '0;
         s_r.fmt.h_skip <= SKIP_RST;
         s_r.fmt.v_skip <= SKIP_RST;
         s_r.fmt.bit_size <= BITSIZE_8;
         s_r.fmt.coding <= COLOUR_UNIT;
         s_r.mode <= XFER_CONT;
         s_r.burst_total <= BURST_RST;
         s_r.expose_cyc <= EXPOSE_RST;
         s_r.period_cyc <= PERIOD_MAX_CYC;
         s_r.rate_mhz <= 32'h0000003D;
         s_r.st <= ST_IDLE;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign s_axi_awready = !s_r.aw_got;
   assign s_axi_wready = !s_r.w_got;
   assign s_axi_bvalid = s_r.bvalid;
   assign s_axi_bresp = s_r.bresp;
   assign s_axi_arready = !s_r.rvalid;
   assign s_axi_rvalid = s_r.rvalid;
   assign s_axi_rdata = s_r.rdata;
   assign s_axi_rresp = s_r.rresp;
   assign stream_pix = s_r.out;
   assign stream_valid = s_r.out_valid;
   assign stream_active = (s_r.st != ST_IDLE);
endmodule : isfa_top

// ===== src/isfa_pkg.sv
package isfa_pkg;
   // register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_FORMAT = 8'h04;
   localparam logic [7:0] REG_PIXFMT = 8'h08;
   localparam logic [7:0] REG_ACQ = 8'h0C;
   localparam logic [7:0] REG_BURST = 8'h10;
   localparam logic [7:0] REG_PERIOD = 8'h14;
   localparam logic [7:0] REG_RATE = 8'h18;
   localparam logic [7:0] REG_EXPOSE = 8'h1C;
   localparam logic [7:0] REG_STATUS = 8'h20;
   localparam logic [7:0] REG_GEOM = 8'h24;
   // control register command bits
   localparam int CMD_BEGIN_BIT = 0;
   localparam int CMD_END_BIT = 1;
   localparam int CMD_KILL_BIT = 2;
   localparam int CHAN_OPEN_BIT = 3;
   // format register fields
   localparam int HSKIP_LSB = 0;
   localparam int VSKIP_LSB = 4;
   localparam int MIRROR_LR_BIT = 8;
   localparam int MIRROR_TB_BIT = 9;
   localparam int PATTERN_LSB = 12;
   localparam int CODING_BIT = 16;
   localparam int BITSIZE_LSB = 20;
   localparam int SLOT_LSB = 24;
   // acquisition register fields
   localparam int MODE_LSB = 0;
   localparam int RATE_ON_BIT = 4;
   localparam int PERIOD_ON_BIT = 5;
   // reset values
   localparam logic [3:0] SKIP_RST = 4'h1;
   localparam logic [3:0] BITSIZE_8 = 4'h8;
   localparam logic [31:0] FMT_GRAY8 = 32'h01080001;
   localparam logic [31:0] FMT_RAW8_BASE = 32'h01080000;
   localparam logic [15:0] BURST_RST = 16'h0001;
   localparam logic [31:0] EXPOSE_RST = 32'h00000400;
   // line geometry reaching the block from the sensor side
   localparam logic [11:0] WIDTH_MAX = 12'h800;
   localparam logic [11:0] HEIGHT_MAX = 12'h800;
   localparam logic [11:0] LINE_GAP = 12'h010;
   // clock and rate limits, test pattern fill levels
   localparam longint CLK_HZ = 200000000;
   localparam real RATE_MIN_HZ = 0.061;
   localparam logic [31:0] PERIOD_MAX_CYC = 32'(longint'(real'(CLK_HZ) / RATE_MIN_HZ));
   localparam logic [7:0] FILL_WHITE = 8'hFF;
   localparam logic [7:0] FILL_GRAY_HI = 8'hAA;
   localparam logic [7:0] FILL_GRAY_LO = 8'h55;

   typedef enum logic [1:0] {XFER_CONT, XFER_BURST, XFER_ONE} isfa_mode_t;
   typedef enum logic [3:0] {
      PAT_OFF, PAT_BLACK, PAT_WHITE, PAT_GRAY_HI, PAT_GRAY_LO,
      PAT_H_RAMP, PAT_V_RAMP, PAT_GRAY_STEPS, PAT_STRIPES
   } isfa_pat_t;

   typedef struct packed {
      logic [7:0] data;
      logic sof;
      logic eol;
   } isfa_pix_t;

   typedef struct packed {
      logic [3:0] h_skip;
      logic [3:0] v_skip;
      logic mirror_lr;
      logic mirror_tb;
      isfa_pat_t pattern;
      logic coding;
      logic [3:0] bit_size;
      logic [1:0] slot;
   } isfa_fmt_t;
endpackage : isfa_pkg

// ===== src/isfa_pattern.sv
module isfa_pattern (
   input wire logic aclk,
   input wire logic aresetn,
   input wire isfa_pkg::isfa_pat_t pattern,
   input wire logic [11:0] x,
   input wire logic [11:0] y,
   input wire logic [7:0] sensor,
   output logic [7:0] pix_out
);
   import isfa_pkg::*;
   typedef struct packed {
      logic [7:0] pix;
   } isfa_pg_state_t;
   isfa_pg_state_t st_r, st_nxt;
   logic [2:0] bar;

   always_comb begin
      st_nxt = st_r;
      bar = x[10:8];
      unique case (pattern)
         PAT_OFF: st_nxt.pix = sensor;
         PAT_BLACK: st_nxt.pix = 8'h00;
         PAT_WHITE: st_nxt.pix = FILL_WHITE;
         PAT_GRAY_HI: st_nxt.pix = FILL_GRAY_HI;
         PAT_GRAY_LO: st_nxt.pix = FILL_GRAY_LO;
         PAT_H_RAMP: st_nxt.pix = x[7:0];
         PAT_V_RAMP: st_nxt.pix = y[7:0];
         PAT_GRAY_STEPS: st_nxt.pix = {x[10:8], 5'h00};
         // mono stand-in for stripes: odd bars bar-scaled with low bits set, even bars inverted-bar levels
         PAT_STRIPES: st_nxt.pix = bar[0] ? {bar, 5'h1F} : {~bar, 5'h00};
         default: st_nxt.pix = 8'h00;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) st_r <= '0;
      else st_r <= st_nxt;
   end
   assign pix_out = st_r.pix;
endmodule : isfa_pattern

// ===== sim/isfa_checker.sv
module isfa_checker #(
   parameter logic COLOUR_UNIT = 1'b0,
   parameter logic [3:0] MOSAIC_DIGIT = 4'h1
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire isfa_pkg::isfa_pix_t stream_pix,
   input wire logic stream_valid,
   input wire logic stream_ready,
   input wire logic stream_active
);
   import isfa_pkg::*;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   sequence s_wr_ctrl;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr == REG_CTRL;
   endsequence
   sequence s_begin;
      s_wr_ctrl ##0 (s_axi_wdata[CMD_BEGIN_BIT] && s_axi_wdata[CHAN_OPEN_BIT] && !stream_active);
   endsequence
   sequence s_kill;
      s_wr_ctrl ##0 s_axi_wdata[CMD_KILL_BIT];
   endsequence
   property p_b_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
   endproperty
   property p_r_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   // an abort may drop a stalled pixel
   property p_s_hold;
      stream_valid && !stream_ready |=> (stream_valid && $stable(stream_pix)) || !stream_active;
   endproperty
   property p_ar_ref;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   property p_b_ans;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
   endproperty
   property p_unmap;
      s_axi_arvalid && s_axi_arready && s_axi_araddr > REG_GEOM |=> s_axi_rvalid && s_axi_rresp == 2'h2;
   endproperty
   property p_fmt;
      s_axi_arvalid && s_axi_arready && s_axi_araddr == REG_PIXFMT |=>
         s_axi_rdata == (COLOUR_UNIT ? (FMT_RAW8_BASE | 32'(MOSAIC_DIGIT)) : 32'h01080001);
   endproperty
   property p_begin;
      s_begin |-> ##[1:4] stream_active;
   endproperty
   property p_kill;
      s_kill |-> ##[1:4] !stream_active;
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("bvalid dropped early");
   a_r_hold: assert property (p_r_hold) else $error("read answer not held");
   a_s_hold: assert property (p_s_hold) else $error("stalled pixel changed");
   a_ar_ref: assert property (p_ar_ref) else $error("arready while rvalid");
   a_b_ans: assert property (p_b_ans) else $error("no write answer");
   a_unmap: assert property (p_unmap) else $error("unmapped read not refused");
   a_fmt: assert property (p_fmt) else $error("format id wrong");
   a_begin: assert property (p_begin) else $error("begin did not start");
   a_kill: assert property (p_kill) else $error("kill did not halt");
endmodule : isfa_checker
bind isfa_top isfa_checker #(.COLOUR_UNIT(COLOUR_UNIT), .MOSAIC_DIGIT(MOSAIC_DIGIT)) u_chk (.aclk, .aresetn,
   .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
   .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
   .s_axi_rready, .stream_pix, .stream_valid, .stream_ready, .stream_active);

// ===== sim/isfa_sink.sv
module isfa_sink (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic slow,
   input wire isfa_pkg::isfa_pix_t stream_pix,
   input wire logic stream_valid,
   output logic stream_ready,
   output logic [11:0] line_len
);
   timeunit 1ns;
   timeprecision 1ps;
   import isfa_pkg::*;
   logic [1:0] ph_r;
   logic [11:0] cnt_r;
   // host stalls one cycle in four when slow
   always_ff @(posedge aclk) begin
      ph_r <= aresetn ? ph_r + 2'h1 : 2'h0;
      stream_ready <= aresetn && (!slow || ph_r != 2'h3);
      if (!aresetn) begin
         cnt_r <= 12'h000;
         line_len <= 12'h000;
      end else if (stream_valid && stream_ready) begin
         cnt_r <= stream_pix.eol ? 12'h000 : cnt_r + 12'h001;
         if (stream_pix.eol) begin
            line_len <= cnt_r + 12'h001;
         end
      end
   end
endmodule : isfa_sink

// ===== sim/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import isfa_pkg::*;
   logic aclk = 1'b0, aresetn = 1'b0, slow = 1'b1, alt = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, sensor_pix = 8'h3C;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, stream_valid, stream_ready;
   logic stream_active;
   logic [1:0] s_axi_bresp, s_axi_rresp, br;
   logic [11:0] line_len;
   isfa_pix_t stream_pix, q;
   int n_fail = 0, check_count = 0, cyc = 0;
   isfa_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sensor_pix, .stream_pix,
      .stream_valid, .stream_ready, .stream_active);
   isfa_sink host (.aclk, .aresetn, .slow, .stream_pix, .stream_valid, .stream_ready, .line_len);
   always #2.5 aclk = ~aclk;
   // alternate pixels so a horizontal pair always sums to 0x58
   always @(posedge aclk) sensor_pix <= alt ? sensor_pix ^ 8'h20 : 8'h3C;
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         close_out();
      end
   end
   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : close_out
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         n_fail++;
         $display("MISMATCH %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!(s_axi_bvalid && s_axi_bready));
      br = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!(s_axi_rvalid && s_axi_rready));
      d = s_axi_rdata;
      s_axi_rready <= 1'b0;
   endtask : rd
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] d;
      rd(a, d);
      chk(d, e);
   endtask : rc
   task automatic px(input int n);
      int k;
      k = 0;
      while (k < n) begin
         @(posedge aclk);
         if (stream_valid && stream_ready) k++;
      end
      q = stream_pix;
   endtask : px
   task automatic go();
      wr(REG_CTRL, 32'h8);
      wr(REG_CTRL, 32'h9);
      repeat (4) @(posedge aclk);
      chk(32'(stream_active), 32'h1);
   endtask : go
   task automatic halt();
      wr(REG_CTRL, 32'h0);
      wr(REG_CTRL, 32'h4);
      repeat (4) @(posedge aclk);
      chk(32'(stream_active), 32'h0);
   endtask : halt
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      rc(REG_FORMAT, 32'h00800011);
      rc(REG_ACQ, 32'h0);
      rc(REG_PIXFMT, 32'h01080001);
      rd(8'h40, v);
      chk(32'(s_axi_rresp), 32'h2);
      chk(v, 32'h0);
      wr(8'h40, 32'h0);
      chk(32'(br), 32'h2);
      rc(REG_GEOM, 32'd4227072);
      wr(REG_FORMAT, 32'h00800081);
      rc(REG_GEOM, 32'd557056);
      wr(REG_FORMAT, 32'h00800011);
      wr(REG_EXPOSE, 32'h01000000);
      rc(REG_GEOM, 32'h01000000);
      wr(REG_EXPOSE, 32'h10);
      chk(32'(br), 32'h0);
      for (int m = 0; m < 3; m++) begin
         wr(REG_ACQ, 32'(m) | 32'h10);
         rc(REG_ACQ, 32'(m) | 32'h10);
      end
      wr(REG_ACQ, 32'h0);
      wr(REG_RATE, 32'd1000);
      repeat (40) @(posedge aclk);
      rc(REG_PERIOD, 32'(64'd200000000000 / 64'd1000));
      wr(REG_RATE, 32'd61);
      repeat (40) @(posedge aclk);
      rc(REG_PERIOD, 32'(64'd200000000000 / 64'd61));
      wr(REG_ACQ, 32'h10);
      rc(REG_GEOM, 32'(64'd200000000000 / 64'd61));
      wr(REG_ACQ, 32'h0);
      wr(REG_PERIOD, 32'd2000000);
      repeat (40) @(posedge aclk);
      rc(REG_RATE, 32'd100000);
      $display("test registers done");
      go();
      wr(REG_FORMAT, 32'h00401022);
      rc(REG_FORMAT, 32'h00801011);
      wr(REG_RATE, 32'd5000);
      wr(REG_ACQ, 32'h30);
      repeat (40) @(posedge aclk);
      rc(REG_RATE, 32'd100000);
      rc(REG_ACQ, 32'h0);
      for (int p = 1; p < 5; p++) begin
         wr(REG_FORMAT, 32'h00800011 | (32'(p) << 12));
         px(20);
         chk(32'(q.data), 32'(p == 2 ? 8'hFF : p == 3 ? 8'hAA : p == 4 ? 8'h55 : 8'h00));
      end
      wr(REG_FORMAT, 32'h00800011);
      px(20);
      chk(32'(q.data), 32'h3C);
      wr(REG_CTRL, 32'h0);
      wr(REG_CTRL, 32'h2);
      repeat (100) @(posedge aclk);
      chk(32'(stream_active), 32'h1);
      rc(REG_STATUS, 32'h3);
      halt();
      $display("test stream one done");
      slow <= 1'b0;
      alt <= 1'b1;
      wr(REG_FORMAT, 32'h00800012);
      go();
      for (int e = 0; e < 2; e++) begin
         do px(1); while (q.eol !== 1'b1);
      end
      // sink registers the length at the eol edge
      @(posedge aclk);
      chk(32'(line_len), 32'd1024);
      px(10);
      chk(32'(q.data), 32'h2C);
      halt();
      $display("test decimation done");
      close_out();
   end
endmodule : testbench
